// File: inc/pad_cfg.svh
`ifndef PAD_CFG_SVH
`define PAD_CFG_SVH

// --------------------------------------------------------------
// Register offsets in the module register space
// --------------------------------------------------------------
`define PAD_OFS_PAGE      8'he0
`define PAD_OFS_OMC_AB    8'h20
`define PAD_OFS_OMC_BC    8'h21
`define PAD_OFS_IMC_A     8'h0a
`define PAD_OFS_IMC_B     8'h0b
`define PAD_OFS_IMC_C     8'h18
`define PAD_PAGE_RESET    8'h00

// --------------------------------------------------------------
// Power management bit positions
// --------------------------------------------------------------
`define PAD_TURBO_BIT     3
`define PAD_BLK_FETCH     0
`define PAD_BLK_RD        1
`define PAD_BLK_WR        2
`define PAD_BLK_ALE       3
`define PAD_BLK_RST       4

// --------------------------------------------------------------
// Logic array input vector layout
// --------------------------------------------------------------
`define PAD_VEC_W         69
`define PAD_V_ADDR        0
`define PAD_V_FETCH       16
`define PAD_V_RD          17
`define PAD_V_WR          18
`define PAD_V_ALE         19
`define PAD_V_RST         20
`define PAD_V_PDN         21
`define PAD_V_PA          22
`define PAD_V_PB          30
`define PAD_V_PC          38
`define PAD_V_PD          42
`define PAD_V_PAGE        44
`define PAD_V_FB          52
`define PAD_V_RDY         68

// --------------------------------------------------------------
// Product term counts and decode term slots
// --------------------------------------------------------------
`define PAD_DEC_TERMS     41
`define PAD_GLA_TERMS     137
`define PAD_T_PRI         0
`define PAD_T_SEC         24
`define PAD_T_SRAM        36
`define PAD_T_REG         38
`define PAD_T_PER         39
`define PAD_PRI_PT        3
`define PAD_SEC_PT        3

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define PAD_CLK_NS        5
`define PAD_STBY_NS       70

`endif

// File: inc/pad_pkg.sv
package pad_pkg;

  typedef logic [68:0] pad_vec_t;

  typedef struct packed {
    pad_vec_t care;
    pad_vec_t val;
  } pad_term_s;

  typedef struct packed {
    logic [7:0] primary_sector_sel;
    logic [3:0] secondary_sector_sel;
    logic       sram_sel;
    logic       module_register_space;
    logic [1:0] periph_sel;
  } pad_sel_s;

endpackage

// File: verilog/pad_pterm_array.sv
`timescale 1ns/100ps
// Bank of AND-array product terms; an all-zero care mask is unprogrammed
module pad_pterm_array #(
  parameter int N = 41
) (
  // Programmed terms
  input  wire pad_pkg::pad_term_s [N-1:0] terms,
  // Array inputs
  input  wire pad_pkg::pad_vec_t          vec,
  // Term results
  output logic [N-1:0]                    hit
);

  always_comb begin
    for (int i = 0; i < N; i++) begin
      hit[i] = (|terms[i].care) && (((vec ^ terms[i].val) & terms[i].care) == '0);
    end
  end

endmodule

// File: verilog/pad_decoder.sv
`timescale 1ns/100ps
`include "pad_cfg.svh"
// Behaviour
// (R1) Eight-bit page register, written and read back by the processor.
// (R2) Page register sits at offset e0 inside the module register space.
// (R3) Page bits map one-to-one onto data lines 0 to 7.
// (R4) Page bits feed the decode array for sector and SRAM selects.
// (R5) Page bits are also inputs of the general logic array.
// (R6) Arrays see address, four strobes, reset, power-down, ports, page, feedback, ready.
// (R7) Turbo bit clear: arrays go to standby after inputs stay still 70 ns.
// (R8) Five power bits each block one control strobe from the arrays.
// (R9) Eight primary sector selects, up to three product terms each.
// (R10) Four secondary sector selects, up to three product terms each.
// (R11) One SRAM select from at most two product terms.
// (R12) One select for the module register space.
// (R13) Two peripheral selects for peripheral I/O mode.
// (R14) Two external chip selects that use no output cell.
// (R15) General array: 20 input cells, 16 output cells, 137 product terms.
// (R16) Processor loads output cells and reads both cell kinds directly.
// (R17) Programmed equations act from power-up without any loading step.
// (R18) Secondary sector select wins over an overlapping primary one.
// (R19) SRAM, register and peripheral selects win over any flash select.
// (R20) Page register clears to zero on reset.
module pad_decoder #(
  parameter int GLA_TERMS = `PAD_GLA_TERMS,
  parameter int STBY_NS   = `PAD_STBY_NS
) (
  // Clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   resetn,
  // Processor bus
  input  wire logic [15:0]                            addr,
  input  wire logic [7:0]                             data_in,
  output logic [7:0]                                  data_out,
  output logic                                        data_out_en,
  input  wire logic                                   program_fetch_strobe_n,
  input  wire logic                                   rd_n,
  input  wire logic                                   wr_n,
  input  wire logic                                   ale,
  // Power management and status
  input  wire logic [7:0]                             power_mgmt_reg0,
  input  wire logic [7:0]                             power_mgmt_reg2,
  input  wire logic                                   power_down_input,
  input  wire logic                                   flash_ready,
  output logic                                        standby,
  // Port pins
  input  wire logic [7:0]                             pa_in,
  input  wire logic [7:0]                             pb_in,
  input  wire logic [3:0]                             pc_in,
  input  wire logic [1:0]                             pd_in,
  // Programmed equations
  input  wire pad_pkg::pad_term_s [`PAD_DEC_TERMS-1:0] dec_terms,
  input  wire pad_pkg::pad_term_s [GLA_TERMS-1:0]     gla_terms,
  input  wire logic [15:0][GLA_TERMS-1:0]             cell_alloc,
  input  wire logic [15:0]                            cell_invert,
  input  wire logic [1:0][GLA_TERMS-1:0]              ecs_alloc,
  // Decode and logic outputs
  output pad_pkg::pad_sel_s                           selects,
  output logic [1:0]                                  ext_chip_sel,
  output logic [15:0]                                 output_cell_q,
  output logic [7:0]                                  page_bits
);

  localparam int STBY_CYC = (STBY_NS + `PAD_CLK_NS - 1) / `PAD_CLK_NS;

  logic [7:0]           page_reg;
  logic [21:0]          pin_s1;
  logic [21:0]          pin_s2;
  logic [21:0]          pin_s3;
  logic [21:0]          pin_reg;
  logic [21:0]          pin_next;
  logic [15:0]          cell_reg;
  logic [15:0]          cell_next;
  logic [1:0]           ecs_reg;
  logic [1:0]           ecs_next;
  pad_pkg::pad_sel_s    sel_reg;
  pad_pkg::pad_sel_s    sel_next;
  pad_pkg::pad_vec_t    vec;
  pad_pkg::pad_vec_t    vec_q;
  logic [`PAD_DEC_TERMS-1:0] dec_hit;
  logic [GLA_TERMS-1:0] gla_hit;
  logic [4:0]           stb;
  logic [4:0]           stable_cnt;
  logic                 standby_reg;
  logic                 changed;
  logic                 active;
  logic                 wr_act_q;
  logic                 wr_start;
  logic                 rd_act;
  logic                 reg_sel;
  logic [7:0]           rd_mux;
  logic [7:0]           data_reg;
  logic                 data_en_reg;
  logic [7:0]           pri_raw;
  logic [3:0]           sec_raw;
  logic                 high_raw;

  // --------------------------------------------------------------
  // Pin synchronisers, change accepted when stages two and three agree
  // --------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= {pd_in, pc_in, pb_in, pa_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign pin_next = (pin_s2 == pin_s3) ? pin_s3 : pin_reg;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  // --------------------------------------------------------------
  // Array input vector with strobe blocking
  // --------------------------------------------------------------
  always_comb begin
    stb                 = {~resetn, ale, wr_n, rd_n, program_fetch_strobe_n};
    if (power_mgmt_reg2[`PAD_BLK_FETCH]) stb[0] = 1'b1; // R8
    if (power_mgmt_reg2[`PAD_BLK_RD]) stb[1] = 1'b1; // R8
    if (power_mgmt_reg2[`PAD_BLK_WR]) stb[2] = 1'b1; // R8
    if (power_mgmt_reg2[`PAD_BLK_ALE]) stb[3] = 1'b0; // R8
    if (power_mgmt_reg2[`PAD_BLK_RST]) stb[4] = 1'b0; // R8
    vec                                   = '0;
    vec[`PAD_V_ADDR +: 16]                = addr; // R6
    vec[`PAD_V_FETCH +: 5]                = stb; // R6
    vec[`PAD_V_PDN]                       = power_down_input;
    vec[`PAD_V_PA +: 22]                  = pin_reg;
    vec[`PAD_V_PAGE +: 8]                 = page_reg; // R4 R5
    vec[`PAD_V_FB +: 16]                  = cell_reg;
    vec[`PAD_V_RDY]                       = flash_ready;
  end

  pad_pterm_array #(
    .N     (`PAD_DEC_TERMS)
  ) u_dec (
    .terms (dec_terms),
    .vec   (vec),
    .hit   (dec_hit)
  );

  pad_pterm_array #(
    .N     (GLA_TERMS)
  ) u_gla (
    .terms (gla_terms),
    .vec   (vec),
    .hit   (gla_hit)
  ); // R15 R17

  // --------------------------------------------------------------
  // Standby after a quiet stretch with turbo off
  // --------------------------------------------------------------
  assign changed = (vec != vec_q);
  assign active  = !standby_reg || changed;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      vec_q       <= '0;
      stable_cnt  <= '0;
      standby_reg <= 1'b0;
    end else begin
      vec_q <= vec;
      if (changed || power_mgmt_reg0[`PAD_TURBO_BIT]) begin
        stable_cnt  <= '0;
        standby_reg <= 1'b0;
      end else if (stable_cnt == 5'(STBY_CYC - 1)) begin
        standby_reg <= 1'b1; // R7
      end else begin
        stable_cnt <= stable_cnt + 5'h01;
      end
    end
  end

  // --------------------------------------------------------------
  // Decode with select priority
  // --------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pri_raw[i] = |dec_hit[`PAD_T_PRI + i*`PAD_PRI_PT +: `PAD_PRI_PT]; // R9
    end
    for (int j = 0; j < 4; j++) begin
      sec_raw[j] = |dec_hit[`PAD_T_SEC + j*`PAD_SEC_PT +: `PAD_SEC_PT]; // R10
    end
    sel_next.sram_sel              = |dec_hit[`PAD_T_SRAM +: 2]; // R11
    sel_next.module_register_space = dec_hit[`PAD_T_REG]; // R12
    sel_next.periph_sel            = dec_hit[`PAD_T_PER +: 2]; // R13
    high_raw = sel_next.sram_sel || sel_next.module_register_space
               || (|sel_next.periph_sel);
    sel_next.secondary_sector_sel = high_raw ? 4'h0 : sec_raw; // R19
    sel_next.primary_sector_sel   = (high_raw || (|sec_raw)) ? 8'h00 : pri_raw; // R18 R19
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sel_reg <= '0;
    end else if (active) begin
      sel_reg <= sel_next;
    end
  end

  // --------------------------------------------------------------
  // Register space access
  // --------------------------------------------------------------
  assign reg_sel  = dec_hit[`PAD_T_REG];
  assign rd_act   = !rd_n && reg_sel;
  assign wr_start = !wr_n && !wr_act_q && reg_sel;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_act_q <= 1'b0;
    end else begin
      wr_act_q <= !wr_n;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      page_reg <= `PAD_PAGE_RESET; // R20
    end else if (wr_start && addr[7:0] == `PAD_OFS_PAGE) begin
      page_reg <= data_in; // R1 R2 R3
    end
  end

  always_comb begin
    unique case (addr[7:0])
      `PAD_OFS_PAGE:   rd_mux = page_reg; // R1 R3
      `PAD_OFS_OMC_AB: rd_mux = cell_reg[7:0]; // R16
      `PAD_OFS_OMC_BC: rd_mux = cell_reg[15:8]; // R16
      `PAD_OFS_IMC_A:  rd_mux = pin_reg[7:0]; // R16
      `PAD_OFS_IMC_B:  rd_mux = pin_reg[15:8]; // R16
      `PAD_OFS_IMC_C:  rd_mux = {4'h0, pin_reg[19:16]}; // R16
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      data_reg    <= 8'h00;
      data_en_reg <= 1'b0;
    end else begin
      data_en_reg <= rd_act;
      if (rd_act) begin
        data_reg <= rd_mux;
      end
    end
  end

  // --------------------------------------------------------------
  // General logic array output cells and external selects
  // --------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      cell_next[k] = (|(gla_hit & cell_alloc[k])) ^ cell_invert[k];
    end
    for (int e = 0; e < 2; e++) begin
      ecs_next[e] = |(gla_hit & ecs_alloc[e]); // R14
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cell_reg <= '0;
    end else begin
      if (active) begin
        cell_reg <= cell_next;
      end
      if (wr_start && addr[7:0] == `PAD_OFS_OMC_AB) begin
        cell_reg[7:0] <= data_in; // R16
      end
      if (wr_start && addr[7:0] == `PAD_OFS_OMC_BC) begin
        cell_reg[15:8] <= data_in; // R16
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ecs_reg <= '0;
    end else if (active) begin
      ecs_reg <= ecs_next;
    end
  end

  assign selects       = sel_reg;
  assign ext_chip_sel  = ecs_reg;
  assign output_cell_q = cell_reg;
  assign page_bits     = page_reg;
  assign data_out      = data_reg;
  assign data_out_en   = data_en_reg;
  assign standby       = standby_reg;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_page_wr;
    wr_start && addr[7:0] == `PAD_OFS_PAGE;
  endsequence

  sequence s_page_rd;
    rd_act && addr[7:0] == `PAD_OFS_PAGE;
  endsequence

  a_page_write: assert property (s_page_wr |=> page_bits == $past(data_in)) // R1
    else $error("page write lost");
  a_page_read: assert property (s_page_rd |=> data_out_en && data_out == $past(page_reg)) // R3
    else $error("page readback wrong");
  a_page_hold: assert property (!(wr_start && addr[7:0] == `PAD_OFS_PAGE)
                                |=> $stable(page_bits)) // R2
    else $error("page changed without write");
  a_page_reset: assert property (@(posedge mclk) disable iff (1'b0)
                                 !resetn |=> page_bits == 8'h00) // R20
    else $error("page not cleared");
  a_sec_prio: assert property (|selects.secondary_sector_sel
                               |-> selects.primary_sector_sel == 8'h00) // R18
    else $error("primary and secondary both selected");
  a_high_prio: assert property ((selects.sram_sel || selects.module_register_space
                                 || |selects.periph_sel)
                                |-> selects.primary_sector_sel == 8'h00
                                    && selects.secondary_sector_sel == 4'h0) // R19
    else $error("flash selected under higher target");
  a_stby_entry: assert property ($rose(standby) |-> !$past(power_mgmt_reg0[`PAD_TURBO_BIT])
                                 && $past(stable_cnt) == 5'(STBY_CYC - 1)) // R7
    else $error("standby entered early");
  a_stby_wake: assert property (power_mgmt_reg0[`PAD_TURBO_BIT] |=> !standby) // R7
    else $error("standby with turbo on");
  a_strobe_blk: assert property ((!power_mgmt_reg2[`PAD_BLK_RD] || vec[`PAD_V_RD])
                                 && (!power_mgmt_reg2[`PAD_BLK_WR] || vec[`PAD_V_WR])) // R8
    else $error("blocked strobe reached array");
  a_cell_load: assert property (wr_start && addr[7:0] == `PAD_OFS_OMC_BC
                                |=> output_cell_q[15:8] == $past(data_in)) // R16
    else $error("cell load lost");
  a_sel_follow: assert property (active |=> selects == $past(sel_next)) // R9 R10
    else $error("selects stale");

endmodule

// File: testbench/pad_cpu_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Processor side of the bus: register reads and writes
// ------------------------------------------------------------
module pad_cpu_model (
  // Clock
  input  wire logic        mclk,
  // Bus towards the decoder
  output logic [15:0]      addr,
  output logic [7:0]       data_in,
  output logic             program_fetch_strobe_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             ale,
  // Read return
  input  wire logic [7:0]  data_out,
  input  wire logic        data_out_en
);
  localparam logic [15:0] REG_BASE = 16'hff00;

  initial begin
    addr                   = 16'h0000;
    data_in                = 8'h00;
    program_fetch_strobe_n = 1'b1;
    rd_n                   = 1'b1;
    wr_n                   = 1'b1;
    ale                    = 1'b0;
  end

  task automatic set_bus(input logic [15:0] a, input logic r);
    @(posedge mclk);
    addr <= a;
    rd_n <= r;
  endtask

  task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
    @(posedge mclk);
    addr    <= REG_BASE | {8'h00, ofs};
    data_in <= d;
    wr_n    <= 1'b0;
    @(posedge mclk);
    wr_n    <= 1'b1;
    data_in <= ~d;
    @(posedge mclk);
  endtask

  task automatic reg_read(input logic [7:0] ofs, output logic [7:0] d, output logic en);
    @(posedge mclk);
    addr <= REG_BASE | {8'h00, ofs};
    rd_n <= 1'b0;
    repeat (2) @(posedge mclk);
    d  = data_out;
    en = data_out_en;
    rd_n <= 1'b1;
  endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/100ps
`include "pad_cfg.svh"
module tb;
  localparam int GLA = 137;
  typedef struct packed {
    logic [7:0]  page;
    logic [15:0] adr;
    logic [15:0] sel;
    logic [1:0]  ecs;
  } pad_row_s;

  logic                                      mclk = 1'b0;
  logic                                      resetn = 1'b0;
  logic [15:0]                               addr;
  logic [7:0]                                data_in;
  logic [7:0]                                data_out;
  logic                                      data_out_en;
  logic                                      fetch_n;
  logic                                      rd_n;
  logic                                      wr_n;
  logic                                      ale;
  logic [7:0]                                power_mgmt_reg0 = 8'h08;
  logic [7:0]                                power_mgmt_reg2 = 8'h00;
  logic                                      standby;
  pad_pkg::pad_term_s [`PAD_DEC_TERMS-1:0]   dec_terms;
  pad_pkg::pad_term_s [GLA-1:0]              gla_terms;
  logic [15:0][GLA-1:0]                      cell_alloc;
  logic [1:0][GLA-1:0]                       ecs_alloc;
  pad_pkg::pad_sel_s                         selects;
  logic [1:0]                                ext_chip_sel;
  logic [15:0]                               output_cell_q;
  logic [7:0]                                page_bits;
  logic [7:0]                                rd_d;
  logic                                      rd_en;
  logic [7:0]                                cur = 8'h00;
  logic [7:0]                                pa_in = 8'h00;
  logic [15:0]                               cell_inv = 16'h0002;
  int                                        errors = 0;
  int                                        compares = 0;

  pad_row_s rows [8] = '{
    '{8'h00, 16'h0000, 16'h0000, 2'h0},
    '{8'h00, 16'ha000, 16'h0100, 2'h0},
    '{8'h00, 16'h9000, 16'h0010, 2'h0},
    '{8'h00, 16'h8100, 16'h0008, 2'h0},
    '{8'h00, 16'hff10, 16'h0004, 2'h0},
    '{8'h01, 16'h1000, 16'h0200, 2'h0},
    '{8'h01, 16'h7f00, 16'h0001, 2'h0},
    '{8'h80, 16'h0000, 16'h0000, 2'h1}
  };

  always #2.5 mclk = ~mclk;

  pad_cpu_model pad_cpu_model_i (
    .mclk                   (mclk),
    .addr                   (addr),
    .data_in                (data_in),
    .program_fetch_strobe_n (fetch_n),
    .rd_n                   (rd_n),
    .wr_n                   (wr_n),
    .ale                    (ale),
    .data_out               (data_out),
    .data_out_en            (data_out_en)
  );

  pad_decoder #(.GLA_TERMS(GLA)) pad_decoder_i (
    .mclk                   (mclk),
    .resetn                 (resetn),
    .addr                   (addr),
    .data_in                (data_in),
    .data_out               (data_out),
    .data_out_en            (data_out_en),
    .program_fetch_strobe_n (fetch_n),
    .rd_n                   (rd_n),
    .wr_n                   (wr_n),
    .ale                    (ale),
    .power_mgmt_reg0        (power_mgmt_reg0),
    .power_mgmt_reg2        (power_mgmt_reg2),
    .power_down_input       (1'b0),
    .flash_ready            (1'b1),
    .standby                (standby),
    .pa_in                  (pa_in),
    .pb_in                  (8'h00),
    .pc_in                  (4'h0),
    .pd_in                  (2'h0),
    .dec_terms              (dec_terms),
    .gla_terms              (gla_terms),
    .cell_alloc             (cell_alloc),
    .cell_invert            (cell_inv),
    .ecs_alloc              (ecs_alloc),
    .selects                (selects),
    .ext_chip_sel           (ext_chip_sel),
    .output_cell_q          (output_cell_q),
    .page_bits              (page_bits)
  );

  function automatic pad_pkg::pad_term_s fld(input pad_pkg::pad_term_s t, input int lo,
                                             input int w, input logic [15:0] v);
    for (int i = 0; i < w; i++) begin
      t.care[lo+i] = 1'b1;
      t.val[lo+i]  = v[i];
    end
    return t;
  endfunction

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Equations: sectors, SRAM, register space, peripherals
  // ------------------------------------------------------------
  initial begin
    dec_terms     = '0;
    gla_terms     = '0;
    cell_alloc    = '0;
    ecs_alloc     = '0;
    dec_terms[0]  = fld('0, `PAD_V_ADDR + 15, 1, 16'h1);
    dec_terms[3]  = fld(fld('0, `PAD_V_ADDR + 15, 1, 16'h0), `PAD_V_PAGE, 1, 16'h1);
    dec_terms[24] = fld('0, `PAD_V_ADDR + 13, 3, 16'h4);
    dec_terms[36] = fld('0, `PAD_V_ADDR + 11, 5, 16'h10);
    dec_terms[38] = fld('0, `PAD_V_ADDR + 8, 8, 16'hff);
    dec_terms[39] = fld('0, `PAD_V_ADDR + 8, 8, 16'h7f);
    dec_terms[40] = fld(fld('0, `PAD_V_ADDR + 8, 8, 16'h7e), `PAD_V_RD, 1, 16'h0);
    gla_terms[0]  = fld('0, `PAD_V_PAGE + 7, 1, 16'h1);
    cell_alloc[0] = GLA'(1);
    ecs_alloc[0]  = GLA'(1);
  end

  initial begin
    #20000;
    errors++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    pa_in  <= 8'h5a;
    @(posedge mclk);
    #1;
    chk("page_bits", 16'h0000, {8'h00, page_bits});
    foreach (rows[i]) begin
      if (rows[i].page !== cur) begin
        pad_cpu_model_i.reg_write(8'he0, rows[i].page);
        cur = rows[i].page;
      end
      pad_cpu_model_i.set_bus(rows[i].adr, 1'b1);
      repeat (2) @(posedge mclk);
      #1;
      chk("selects", rows[i].sel, selects);
      chk("ext_chip_sel", {14'h0, rows[i].ecs}, {14'h0, ext_chip_sel});
    end
    pad_cpu_model_i.reg_read(8'h20, rd_d, rd_en);
    chk("cells_ab", 16'h0103, {7'h0, rd_en, rd_d});
    pad_cpu_model_i.reg_write(8'he0, 8'ha5);
    #1;
    chk("page_bits", 16'h00a5, {8'h00, page_bits});
    pad_cpu_model_i.reg_write(8'h55, 8'h3c);
    pad_cpu_model_i.reg_write(8'h21, 8'h96);
    pad_cpu_model_i.reg_read(8'he0, rd_d, rd_en);
    chk("page_read", 16'h01a5, {7'h0, rd_en, rd_d});
    pad_cpu_model_i.reg_read(8'h55, rd_d, rd_en);
    chk("unmapped_read", 16'h0000, {8'h0, rd_d});
    // Input cells and output cell polarity
    cell_inv <= 16'h0003;
    pad_cpu_model_i.reg_read(8'h0a, rd_d, rd_en);
    chk("pins_a", 16'h015a, {7'h0, rd_en, rd_d});
    chk("cells", 16'h0002, output_cell_q);
    // Peripheral select on a read strobe, then strobe blocked
    pad_cpu_model_i.set_bus(16'h7e00, 1'b0);
    repeat (2) @(posedge mclk);
    #1;
    chk("selects", 16'h0002, selects);
    @(posedge mclk);
    power_mgmt_reg2 <= 8'h02;
    repeat (2) @(posedge mclk);
    #1;
    chk("selects", 16'h0200, selects);
    @(posedge mclk);
    power_mgmt_reg2 <= 8'h00;
    pad_cpu_model_i.set_bus(16'h0000, 1'b1);
    // Standby with turbo off
    @(posedge mclk);
    power_mgmt_reg0 <= 8'h00;
    repeat (20) @(posedge mclk);
    #1;
    chk("standby", 16'h0001, {15'h0, standby});
    pad_cpu_model_i.set_bus(16'h0001, 1'b1);
    repeat (2) @(posedge mclk);
    #1;
    chk("standby", 16'h0000, {15'h0, standby});
    // Reset in mid-run
    @(posedge mclk);
    power_mgmt_reg0 <= 8'h08;
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("page_bits", 16'h0000, {8'h00, page_bits});
    chk("selects", 16'h0000, selects);
    @(posedge mclk);
    resetn <= 1'b1;
    pad_cpu_model_i.reg_read(8'he0, rd_d, rd_en);
    chk("page_read", 16'h0100, {7'h0, rd_en, rd_d});
    finish_test();
  end
endmodule
